/* File: rtl/pced_pkg.sv */
// Package for the pin change edge detector: register map, field widths, reset values.
// Assumes a single 20 MHz system clock and a plain strobe register port.
package pced_pkg;

  localparam int PIN_COUNT = 8;
  localparam int ADDR_WIDTH = 4;
  localparam int DATA_WIDTH = 8;

  localparam logic [ADDR_WIDTH-1:0] RISE_EN_OFFSET = 4'h0;
  localparam logic [ADDR_WIDTH-1:0] FALL_EN_OFFSET = 4'h1;
  localparam logic [ADDR_WIDTH-1:0] FLAG_OFFSET = 4'h2;
  localparam logic [ADDR_WIDTH-1:0] IRQ_STATUS_OFFSET = 4'h3;
  localparam logic [ADDR_WIDTH-1:0] IRQ_MASK_OFFSET = 4'h4;
  localparam logic [ADDR_WIDTH-1:0] PIN_LEVEL_OFFSET = 4'h5;

  localparam logic [DATA_WIDTH-1:0] ENABLE_RESET = 8'h00;
  localparam logic [DATA_WIDTH-1:0] FLAG_RESET = 8'h00;
  localparam logic [DATA_WIDTH-1:0] IRQ_MASK_RESET = 8'h00;
  localparam logic [DATA_WIDTH-1:0] UNMAPPED_READ = 8'h00;
  localparam logic [PIN_COUNT-1:0] PIN_RESET = 8'h00;

  // Status register layout: bit 0 is the port change event.
  localparam int IRQ_BITS = 1;
  localparam int IRQ_CHANGE_BIT = 0;

  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] wdata;
    logic wr;
    logic rd;
  } pced_req_type;

endpackage : pced_pkg

/* File: rtl/pced_top.sv */
// Pin change edge detector for one eight-pin port with a strobe register port.
// Assumes pins are already synchronous to sys_clk and a master that never waits.
//
// Contract
// - Rising enable set: rising edge is an event.
// - Falling enable set: falling edge is an event.
// - Disabled direction never sets the pin flag.
// - Enabled edge sets that pin's change flag.
// - Flag stays clear until event; software clears.
// - Enabled edge also raises port status, irq status; interrupt only if mask bit 0 set.
// - Eight bits each pin register, bit n is pin n; status, mask use bit 0 only.
`timescale 1ns/1ns
module pced_top
  import pced_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire pced_pkg::pced_req_type bus_req,
  output logic [pced_pkg::DATA_WIDTH-1:0] rdata,
  input wire logic [pced_pkg::PIN_COUNT-1:0] port_pins,
  output logic port_change_status,
  output logic irq
);
  import pced_pkg::*;

  logic [PIN_COUNT-1:0] rise_en_r, rise_en_nxt;
  logic [PIN_COUNT-1:0] fall_en_r, fall_en_nxt;
  logic [PIN_COUNT-1:0] flag_r, flag_nxt;
  logic [PIN_COUNT-1:0] pin_prev_r, pin_prev_nxt;
  logic [PIN_COUNT-1:0] pin_event;
  logic [IRQ_BITS-1:0] irq_status_r, irq_status_nxt;
  logic [IRQ_BITS-1:0] irq_mask_r, irq_mask_nxt;
  logic [DATA_WIDTH-1:0] rdata_nxt;
  logic [DATA_WIDTH-1:0] irq_wdata;

  assign irq_wdata = bus_req.wdata;

  // One detector per pin; pins arrive synchronous, so one stored sample suffices.
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
      assign pin_event[gi] =
        (rise_en_r[gi] & ~pin_prev_r[gi] & port_pins[gi]) |
        (fall_en_r[gi] & pin_prev_r[gi] & ~port_pins[gi]);
    end
  endgenerate

  always_comb begin
    pin_prev_nxt = port_pins;
    rise_en_nxt = rise_en_r;
    fall_en_nxt = fall_en_r;
    flag_nxt = flag_r;
    irq_mask_nxt = irq_mask_r;
    irq_status_nxt = irq_status_r;
    if (bus_req.wr) begin
      case (bus_req.addr)
        RISE_EN_OFFSET: rise_en_nxt = bus_req.wdata;
        FALL_EN_OFFSET: fall_en_nxt = bus_req.wdata;
        // Writing 0 clears a flag; writing 1 leaves it as it was.
        FLAG_OFFSET: flag_nxt = flag_r & bus_req.wdata;
        IRQ_STATUS_OFFSET: irq_status_nxt = irq_status_r & ~irq_wdata[IRQ_BITS-1:0];
        IRQ_MASK_OFFSET: irq_mask_nxt = irq_wdata[IRQ_BITS-1:0];
        default: ;
      endcase
    end
    // Hardware set is applied last so an edge in the clearing cycle is kept.
    flag_nxt = flag_nxt | pin_event;
    if (|pin_event) begin
      irq_status_nxt[IRQ_CHANGE_BIT] = 1'b1;
    end
  end

  always_comb begin
    rdata_nxt = UNMAPPED_READ;
    if (bus_req.rd) begin
      case (bus_req.addr)
        RISE_EN_OFFSET: rdata_nxt = rise_en_r;
        FALL_EN_OFFSET: rdata_nxt = fall_en_r;
        FLAG_OFFSET: rdata_nxt = flag_r;
        IRQ_STATUS_OFFSET: rdata_nxt = {{(DATA_WIDTH-IRQ_BITS){1'b0}}, irq_status_r};
        IRQ_MASK_OFFSET: rdata_nxt = {{(DATA_WIDTH-IRQ_BITS){1'b0}}, irq_mask_r};
        PIN_LEVEL_OFFSET: rdata_nxt = pin_prev_r;
        default: rdata_nxt = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rise_en_r <= ENABLE_RESET;
      fall_en_r <= ENABLE_RESET;
      flag_r <= FLAG_RESET;
      pin_prev_r <= PIN_RESET;
      irq_status_r <= '0;
      irq_mask_r <= IRQ_MASK_RESET[IRQ_BITS-1:0];
      rdata <= UNMAPPED_READ;
    end else begin
      rise_en_r <= rise_en_nxt;
      fall_en_r <= fall_en_nxt;
      flag_r <= flag_nxt;
      pin_prev_r <= pin_prev_nxt;
      irq_status_r <= irq_status_nxt;
      irq_mask_r <= irq_mask_nxt;
      rdata <= rdata_nxt;
    end
  end

  // Port status is the OR of the pin flags, so it falls once software clears them all.
  assign port_change_status = |flag_r;
  assign irq = |(irq_status_r & irq_mask_r);

endmodule : pced_top

/* File: sim/pced_assertions.sv */
// Port checker for pced_top.
// Sees only the top ports; pins move just after a clock edge.
`timescale 1ns/1ns
module pced_assertions
  import pced_pkg::*;
(input logic sys_clk, rstn, irq, port_change_status, input logic [7:0] rdata, port_pins,
  input pced_pkg::pced_req_type bus_req);
  logic [7:0] pp;
  always_ff @(posedge sys_clk) pp <= port_pins;
  wire s = port_change_status, w = bus_req.wr, r = bus_req.rd, e = port_pins != pp;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_set; $rose(s) |-> $past(e); endproperty
  a_set: assert property (p_set) else $error("set");
  property p_hold; !$past(e || w) |-> $stable(s); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_clr; $fell(s) |-> $past(w && bus_req.addr == FLAG_OFFSET); endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_rdf; $past(r && bus_req.addr == FLAG_OFFSET) |-> (rdata != 8'h00) == $past(s); endproperty
  a_rdf: assert property (p_rdf) else $error("rdf");
  property p_irq; $rose(irq) |-> $past(e || w); endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_ack; $fell(irq) |-> $past(w); endproperty
  a_ack: assert property (p_ack) else $error("ack");
  property p_idle; !$past(r) |-> rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_gap; $past(r && bus_req.addr > 4'h5) |-> rdata == 8'h00; endproperty
  a_gap: assert property (p_gap) else $error("gap");
endmodule : pced_assertions
bind pced_top pced_assertions chk (.sys_clk, .rstn, .irq, .port_change_status, .rdata,
  .port_pins, .bus_req);

/* File: sim/pced_pin_model.sv */
// Far-side pin model.
// Levels move only just after a clock edge, as the block expects.
`timescale 1ns/1ns
module pced_pin_model (input logic sys_clk, input logic [7:0] target,
  output logic [7:0] pins = 8'h00);
  always @(posedge sys_clk) pins <= target;
endmodule : pced_pin_model

/* File: sim/tb_pin_change_edge_detector.sv */
// Bench for pced_top: rows of pin level, register access and expected outputs.
// Assumes the pin model; each row waits out the two-edge flag latency.
`timescale 1ns/1ns
module tb_pin_change_edge_detector;
  logic sys_clk = 1'h0, rstn = 1'h0, pcs, irq;
  logic [7:0] rdata, pins, t = 8'h00;
  pced_pkg::pced_req_type q = '0;
  int err_total = 0, checks_done = 0;
  // Row digits: expected irq and status, pin level, write, address, data.
  logic [27:0] ops [20] = '{28'h0000000, 28'h0000100, 28'h0000200, 28'h0000300, 28'h0000400,
    28'h0000500, 28'h0000f00, 28'h000100f, 28'h00011f0, 28'h1ff020f, 28'h1ff05ff, 28'h0ff1200,
    28'h10002f0, 28'h1000301, 28'h3001401, 28'h1001301, 28'h1001230, 28'h1000230, 28'h0001200,
    28'h0000200};
  pced_top DUT (.sys_clk, .rstn, .bus_req(q), .rdata, .port_pins(pins),
    .port_change_status(pcs), .irq);
  pced_pin_model pm (.sys_clk, .target(t), .pins);
  initial forever #25 sys_clk = ~sys_clk;
  task chk(string n, logic [7:0] s, e);
    checks_done++;
    err_total += int'(s !== e);
    if (s !== e) $display("MISMATCH %s exp %h got %h", n, e, s);
  endtask : chk
  task acc(logic w, logic [3:0] a, logic [7:0] d);
    @(posedge sys_clk) q <= '{a, d, w, !w};
    @(posedge sys_clk) q <= '0;
    @(negedge sys_clk) if (!w) chk("rdata", rdata, d);
  endtask : acc
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'h1;
    foreach (ops[i]) begin
      t <= ops[i][23:16];
      repeat (2) @(posedge sys_clk);
      acc(ops[i][12], ops[i][11:8], ops[i][7:0]);
      chk("irq_status", {6'h00, irq, pcs}, {6'h00, ops[i][25:24]});
      $display("row %0d done", i);
    end
    conclude();
  end
endmodule : tb_pin_change_edge_detector
